//--- rie_host_model.sv
// Host end of the interrupt line: board pull-up and level decode
`timescale 1ns/1ps
module rie_host_model (
  // Pin from the device
  input wire logic i_pin_out,
  input wire logic i_pin_oe,
  // Pin setup the host programmed
  input wire logic i_push_pull,
  input wire logic i_active_low,
  // Board level and its meaning
  output logic o_pin_wire,
  output logic o_irq_seen
);
  // Pull-up holds the line high when the device lets go
  assign o_pin_wire = i_pin_oe ? i_pin_out : 1'b1;
  // Open drain is always active low; push-pull follows polarity
  assign o_irq_seen = i_push_pull ?
    o_pin_wire ^ i_active_low : !o_pin_wire;
endmodule

//--- rie_irq_enable_logic.sv
// Interrupt enable, sticky status and pin control of the dual repeater
`timescale 1ns/1ps
module rie_irq_enable_logic (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Register access port from the serial front end
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  // General-purpose pins and their trigger mode
  input wire logic i_pin0,
  input wire logic i_pin1,
  input wire logic i_pin0_trigger_select,
  input wire logic i_pin1_trigger_select,
  // Port events, one-cycle pulses or levels from repeater logic
  input wire logic i_port0_wake_evt,
  input wire logic i_port1_wake_evt,
  input wire logic i_port0_detach_evt,
  input wire logic i_port1_detach_evt,
  input wire logic i_port0_attach_evt,
  input wire logic i_port1_attach_evt,
  input wire logic i_port0_overvolt_evt,
  input wire logic i_port1_overvolt_evt,
  input wire logic i_embedded_host_phy_down,
  // Interrupt pin
  output logic o_irq_pin_out,
  output logic o_irq_pin_oe
);
  import rie_pkg::*;

  logic [7:0] irq_enable_first;
  logic [7:0] irq_enable_second;
  logic [7:0] status_first;
  logic [7:0] status_second;
  logic drive_push_pull;
  logic drive_active_low;
  logic [7:0] next_status_first;
  logic [7:0] next_status_second;
  logic [7:0] set_first;
  logic [7:0] set_second;
  logic [7:0] clear_first;
  logic [7:0] clear_second;
  logic pin0_rise_hit;
  logic pin0_fall_hit;
  logic pin1_rise_hit;
  logic pin1_fall_hit;
  logic irq_request;
  logic wr_enable_first;
  logic wr_enable_second;
  logic wr_config;
  logic wr_status_first;
  logic wr_status_second;

  // Pin condition detectors
  rie_pin_watch u_pin0_watch (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_pin(i_pin0),
    .i_trigger_select(i_pin0_trigger_select),
    .o_rise_hit(pin0_rise_hit),
    .o_fall_hit(pin0_fall_hit)
  );

  rie_pin_watch u_pin1_watch (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_pin(i_pin1),
    .i_trigger_select(i_pin1_trigger_select),
    .o_rise_hit(pin1_rise_hit),
    .o_fall_hit(pin1_fall_hit)
  );

  // Address decode of writes
  assign wr_enable_first = i_reg_wr && (i_reg_addr == RIE_ENABLE_FIRST_OFS);
  assign wr_enable_second = i_reg_wr &&
    (i_reg_addr == RIE_ENABLE_SECOND_OFS);
  assign wr_config = i_reg_wr && (i_reg_addr == RIE_GLOBAL_CONFIG_OFS);
  assign wr_status_first = i_reg_wr && (i_reg_addr == RIE_STATUS_FIRST_OFS);
  assign wr_status_second = i_reg_wr &&
    (i_reg_addr == RIE_STATUS_SECOND_OFS);

  // First enable register, all eight bits writable
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      irq_enable_first <= RIE_ENABLE_RESET;
    end else if (wr_enable_first) begin
      irq_enable_first <= i_reg_wdata;
    end
  end

  // Second enable register; bits 5-4 stay zero
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      irq_enable_second <= RIE_ENABLE_RESET;
    end else if (wr_enable_second) begin
      irq_enable_second <= i_reg_wdata & RIE_SECOND_WMASK;
    end
  end

  // Pin drive style and polarity, reset to open-drain
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      drive_push_pull <= RIE_CONFIG_RESET[1];
      drive_active_low <= RIE_CONFIG_RESET[0];
    end else if (wr_config) begin
      drive_push_pull <= i_reg_wdata[RIE_DRIVE_STYLE_BIT];
      drive_active_low <= i_reg_wdata[RIE_POLARITY_BIT];
    end
  end

  // Event sources for the first status register
  always_comb begin
    set_first = 8'h00;
    set_first[RIE_PIN1_RISE_BIT] = pin1_rise_hit;
    set_first[RIE_PIN1_FALL_BIT] = pin1_fall_hit;
    set_first[RIE_PIN0_RISE_BIT] = pin0_rise_hit;
    set_first[RIE_PIN0_FALL_BIT] = pin0_fall_hit;
    set_first[RIE_PORT1_WAKE_BIT] = i_port1_wake_evt;
    set_first[RIE_PORT1_DETACH_BIT] = i_port1_detach_evt;
    set_first[RIE_PORT0_WAKE_BIT] = i_port0_wake_evt;
    set_first[RIE_PORT0_DETACH_BIT] = i_port0_detach_evt;
  end

  // Attach is only detected while enabled and the host phy is down
  always_comb begin
    set_second = 8'h00;
    set_second[RIE_PORT1_ATTACH_BIT] = i_port1_attach_evt &
      i_embedded_host_phy_down &
      irq_enable_second[RIE_PORT1_ATTACH_BIT];
    set_second[RIE_PORT0_ATTACH_BIT] = i_port0_attach_evt &
      i_embedded_host_phy_down &
      irq_enable_second[RIE_PORT0_ATTACH_BIT];
    set_second[RIE_PORT1_OVERVOLT_BIT] = i_port1_overvolt_evt;
    set_second[RIE_PORT0_OVERVOLT_BIT] = i_port0_overvolt_evt;
  end

  // Write-one-to-clear masks; a zero leaves the flag alone
  assign clear_first = wr_status_first ? i_reg_wdata : 8'h00;
  assign clear_second = wr_status_second ?
    (i_reg_wdata & RIE_STATUS_SECOND_MASK) : 8'h00;

  // Set wins over a clear in the same cycle so no event is lost
  assign next_status_first = (status_first & ~clear_first) | set_first;
  assign next_status_second = ((status_second & ~clear_second) |
    set_second) & RIE_STATUS_SECOND_MASK;

  // Sticky flags
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      status_first <= RIE_STATUS_RESET;
      status_second <= RIE_STATUS_RESET;
    end else begin
      status_first <= next_status_first;
      status_second <= next_status_second;
    end
  end

  // Any enabled flag requests the pin; each bit pairs with its enable
  assign irq_request =
    (status_first[RIE_PIN1_RISE_BIT] &
      irq_enable_first[RIE_PIN1_RISE_BIT]) |
    (status_first[RIE_PIN1_FALL_BIT] &
      irq_enable_first[RIE_PIN1_FALL_BIT]) |
    (status_first[RIE_PIN0_RISE_BIT] &
      irq_enable_first[RIE_PIN0_RISE_BIT]) |
    (status_first[RIE_PIN0_FALL_BIT] &
      irq_enable_first[RIE_PIN0_FALL_BIT]) |
    (status_first[RIE_PORT1_WAKE_BIT] &
      irq_enable_first[RIE_PORT1_WAKE_BIT]) |
    (status_first[RIE_PORT1_DETACH_BIT] &
      irq_enable_first[RIE_PORT1_DETACH_BIT]) |
    (status_first[RIE_PORT0_WAKE_BIT] &
      irq_enable_first[RIE_PORT0_WAKE_BIT]) |
    (status_first[RIE_PORT0_DETACH_BIT] &
      irq_enable_first[RIE_PORT0_DETACH_BIT]) |
    (status_second[RIE_PORT1_ATTACH_BIT] &
      irq_enable_second[RIE_PORT1_ATTACH_BIT]) |
    (status_second[RIE_PORT0_ATTACH_BIT] &
      irq_enable_second[RIE_PORT0_ATTACH_BIT]) |
    (status_second[RIE_PORT1_OVERVOLT_BIT] &
      irq_enable_second[RIE_PORT1_OVERVOLT_BIT]) |
    (status_second[RIE_PORT0_OVERVOLT_BIT] &
      irq_enable_second[RIE_PORT0_OVERVOLT_BIT]);

  // Pin driver; registered so the pin never glitches on decode
  rie_pin_drive u_pin_drive (
    .i_ref_clk(i_ref_clk),
    .i_reset(i_reset),
    .i_irq_request(irq_request),
    .i_force_en(irq_enable_second[RIE_FORCE_EN_BIT]),
    .i_force_value(irq_enable_second[RIE_FORCE_VALUE_BIT]),
    .i_push_pull(drive_push_pull),
    .i_active_low(drive_active_low),
    .o_pin_out(o_irq_pin_out),
    .o_pin_oe(o_irq_pin_oe)
  );

  // Read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_reg_rdata <= RIE_UNMAPPED_DATA;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        RIE_STATUS_FIRST_OFS: o_reg_rdata <= status_first;
        RIE_STATUS_SECOND_OFS: o_reg_rdata <= status_second;
        RIE_ENABLE_FIRST_OFS: o_reg_rdata <= irq_enable_first;
        RIE_ENABLE_SECOND_OFS: o_reg_rdata <= irq_enable_second;
        RIE_GLOBAL_CONFIG_OFS: begin
          o_reg_rdata <= RIE_UNMAPPED_DATA;
          o_reg_rdata[RIE_DRIVE_STYLE_BIT] <= drive_push_pull;
          o_reg_rdata[RIE_POLARITY_BIT] <= drive_active_low;
        end
        default: o_reg_rdata <= RIE_UNMAPPED_DATA;
      endcase
    end
  end
endmodule

//--- rie_irq_sva.sv
// Port checker for the interrupt enable block
`timescale 1ns/1ps
module rie_irq_sva (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Register port
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  input wire logic [7:0] o_reg_rdata,
  // Event and pin
  input wire logic i_port0_detach_evt,
  input wire logic o_irq_pin_out,
  input wire logic o_irq_pin_oe
);
  logic [7:0] en1;
  logic [7:0] en2;
  logic pp;
  logic pol;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  // Shadow of the controls, so pin checks need no view inside
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      en1 <= 8'h00;
      en2 <= 8'h00;
      pp <= 1'b0;
      pol <= 1'b0;
    end else if (i_reg_wr) begin
      if (i_reg_addr == 8'hB3) en1 <= i_reg_wdata;
      if (i_reg_addr == 8'hB4) en2 <= i_reg_wdata;
      if (i_reg_addr == 8'hB2) pp <= i_reg_wdata[4];
      if (i_reg_addr == 8'hB2) pol <= i_reg_wdata[3];
    end
  end
  reset_out_a: assert property ($fell(i_reset) |->
    o_reg_rdata == 8'h00 && !o_irq_pin_oe) else $error("reset outputs");
  unmapped_read_a: assert property (i_reg_rd && !(i_reg_addr inside
    {8'hA3, 8'hA4, 8'hB2, 8'hB3, 8'hB4}) |=> o_reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
    else $error("read data moved");
  enable1_read_a: assert property (i_reg_rd && i_reg_addr == 8'hB3
    |=> o_reg_rdata == $past(en1)) else $error("first enable read");
  enable2_read_a: assert property (i_reg_rd && i_reg_addr == 8'hB4
    |=> o_reg_rdata == ($past(en2) & 8'hCF)) else $error("second read");
  force_level_a: assert property (en2[7] && $past(en2) == en2
    && !pp && !$past(pp) |-> o_irq_pin_oe == en2[6])
    else $error("forced level wrong");
  open_drain_a: assert property (!pp && !$past(pp) |-> !o_irq_pin_out)
    else $error("open drain drove high");
  push_pull_a: assert property (pp && $past(pp) |-> o_irq_pin_oe)
    else $error("push-pull not driving");
  detach_raise_a: assert property (en1[0] && !en2[7] && !pp
    && i_port0_detach_evt |-> ##2 o_irq_pin_oe) else $error("no raise");
endmodule
bind rie_irq_enable_logic rie_irq_sva i_rie_irq_sva (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
  .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .i_port0_detach_evt(i_port0_detach_evt),
  .o_irq_pin_out(o_irq_pin_out), .o_irq_pin_oe(o_irq_pin_oe)
);

//--- rie_pin_drive.sv
// Interrupt pin driver with override, drive style and polarity
`timescale 1ns/1ps
module rie_pin_drive (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Request and configuration
  input wire logic i_irq_request,
  input wire logic i_force_en,
  input wire logic i_force_value,
  input wire logic i_push_pull,
  input wire logic i_active_low,
  // Pin
  output logic o_pin_out,
  output logic o_pin_oe
);
  import rie_pkg::*;

  logic asserted;

  // Override replaces the event logic entirely
  assign asserted = i_force_en ? i_force_value : i_irq_request;

  // Open-drain pulls low only when asserted; push-pull always drives
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pin_out <= 1'b0;
      o_pin_oe <= 1'b0;
    end else if (i_push_pull) begin
      o_pin_out <= asserted ^ i_active_low;
      o_pin_oe <= 1'b1;
    end else begin
      o_pin_out <= 1'b0;
      o_pin_oe <= asserted;
    end
  end
endmodule

//--- rie_pin_watch.sv
// Synchroniser and edge/level detector for one general-purpose pin
`timescale 1ns/1ps
module rie_pin_watch (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_reset,
  // Pin and mode
  input wire logic i_pin,
  input wire logic i_trigger_select,
  // Detected conditions
  output logic o_rise_hit,
  output logic o_fall_hit
);
  import rie_pkg::*;

  logic sync_first;
  logic sync_second;
  logic prev_level;
  logic prev_valid;
  logic [1:0] settle;

  // Two flops before any logic sees the pin
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      sync_first <= 1'b0;
      sync_second <= 1'b0;
    end else begin
      sync_first <= i_pin;
      sync_second <= sync_first;
    end
  end

  // Previous level; valid waits until the cleared synchroniser has
  // refilled, so a pin already high at release is not taken as an edge
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      prev_level <= 1'b0;
      settle <= 2'h0;
      prev_valid <= 1'b0;
    end else begin
      prev_level <= sync_second;
      settle <= {settle[0], 1'b1};
      prev_valid <= settle[1];
    end
  end

  // Edge mode fires once per edge, level mode fires every cycle
  always_comb begin
    if (i_trigger_select == RIE_TRIGGER_LEVEL) begin
      o_rise_hit = sync_second;
      o_fall_hit = ~sync_second;
    end else begin
      o_rise_hit = prev_valid & sync_second & ~prev_level;
      o_fall_hit = prev_valid & ~sync_second & prev_level;
    end
  end
endmodule

//--- rie_pkg.sv
// Constants shared by the repeater interrupt enable logic
// Notes on behaviour
// - Enable bit 7: pin1 rise edge/high level
// - Enable bit 6: pin1 fall edge/low level
// - Enable bit 5: pin0 rise edge/high level
// - Enable bit 4: pin0 fall edge/low level
// - Trigger select 0 edge, 1 level
// - Enable bit 3 gates port1 remote wake
// - Enable bit 2 gates port1 disconnect
// - Enable bit 1 gates port0 remote wake
// - Enable bit 0 gates port0 disconnect
// - Second bit 7 overrides interrupt pin
// - Second bit 6 is forced pin state
// - Asserted level follows drive style, polarity
// - Second bit 3: port1 attach while phy down
// - Second bit 2: port0 attach while phy down
// - Second bit 1 gates port1 over-voltage
// - Second bit 0 gates port0 over-voltage
// - Enables at B3h, B4h, reset 00h
// - Sticky flags set by hardware, write-1-clear
// - Drive style 0 open-drain, 1 push-pull
// - Polarity 0 high, 1 low; push-pull only
package rie_pkg;
  // Register offsets
  localparam logic [7:0] RIE_STATUS_FIRST_OFS = 8'hA3;
  localparam logic [7:0] RIE_STATUS_SECOND_OFS = 8'hA4;
  localparam logic [7:0] RIE_GLOBAL_CONFIG_OFS = 8'hB2;
  localparam logic [7:0] RIE_ENABLE_FIRST_OFS = 8'hB3;
  localparam logic [7:0] RIE_ENABLE_SECOND_OFS = 8'hB4;
  // Reset values
  localparam logic [7:0] RIE_ENABLE_RESET = 8'h00;
  localparam logic [7:0] RIE_STATUS_RESET = 8'h00;
  localparam logic [1:0] RIE_CONFIG_RESET = 2'h0;
  localparam logic [7:0] RIE_UNMAPPED_DATA = 8'h00;
  // First enable and first status field positions
  localparam int RIE_PIN1_RISE_BIT = 7;
  localparam int RIE_PIN1_FALL_BIT = 6;
  localparam int RIE_PIN0_RISE_BIT = 5;
  localparam int RIE_PIN0_FALL_BIT = 4;
  localparam int RIE_PORT1_WAKE_BIT = 3;
  localparam int RIE_PORT1_DETACH_BIT = 2;
  localparam int RIE_PORT0_WAKE_BIT = 1;
  localparam int RIE_PORT0_DETACH_BIT = 0;
  // Second enable and second status field positions
  localparam int RIE_FORCE_EN_BIT = 7;
  localparam int RIE_FORCE_VALUE_BIT = 6;
  localparam int RIE_PORT1_ATTACH_BIT = 3;
  localparam int RIE_PORT0_ATTACH_BIT = 2;
  localparam int RIE_PORT1_OVERVOLT_BIT = 1;
  localparam int RIE_PORT0_OVERVOLT_BIT = 0;
  localparam logic [7:0] RIE_SECOND_WMASK = 8'hCF;
  localparam logic [7:0] RIE_STATUS_SECOND_MASK = 8'h0F;
  // Global configuration field positions
  localparam int RIE_DRIVE_STYLE_BIT = 4;
  localparam int RIE_POLARITY_BIT = 3;
  // Trigger select encoding
  localparam logic RIE_TRIGGER_EDGE = 1'b0;
  localparam logic RIE_TRIGGER_LEVEL = 1'b1;
endpackage

//--- tb_rie_irq_enable_logic.sv
// Self-checking bench for the interrupt enable block
`timescale 1ns/1ps
module tb_rie_irq_enable_logic;
  typedef struct packed {
    logic [7:0] evt, ea, ed, sa, sd;
  } rie_row_type;
  // Event bit, enable place, status place for each source
  localparam rie_row_type ROWS [8] = '{
    '{8'h01, 8'hB3, 8'h02, 8'hA3, 8'h02},
    '{8'h02, 8'hB3, 8'h01, 8'hA3, 8'h01},
    '{8'h04, 8'hB3, 8'h08, 8'hA3, 8'h08},
    '{8'h08, 8'hB3, 8'h04, 8'hA3, 8'h04},
    '{8'h10, 8'hB4, 8'h04, 8'hA4, 8'h04},
    '{8'h20, 8'hB4, 8'h08, 8'hA4, 8'h08},
    '{8'h40, 8'hB4, 8'h01, 8'hA4, 8'h01},
    '{8'h80, 8'hB4, 8'h02, 8'hA4, 8'h02}};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] evt = 8'h00;
  logic [7:0] rdata;
  logic [1:0] pins = 2'h0;
  logic [1:0] trig = 2'h0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic phy_down = 1'b1;
  logic pp = 1'b0;
  logic pol = 1'b0;
  logic pin_out, pin_oe, irq_seen;
  int mismatches = 0;
  int total_checks = 0;
  initial forever #2.5 clk = ~clk;
  rie_irq_enable_logic i_rie_irq_enable_logic (
    .i_ref_clk(clk), .i_reset(rst), .i_reg_addr(addr), .i_reg_wr(wr_en),
    .i_reg_wdata(wdata), .i_reg_rd(rd_en), .o_reg_rdata(rdata),
    .i_pin0(pins[0]), .i_pin1(pins[1]), .i_pin0_trigger_select(trig[0]),
    .i_pin1_trigger_select(trig[1]), .i_port0_wake_evt(evt[0]),
    .i_port0_detach_evt(evt[1]), .i_port1_wake_evt(evt[2]),
    .i_port1_detach_evt(evt[3]), .i_port0_attach_evt(evt[4]),
    .i_port1_attach_evt(evt[5]), .i_port0_overvolt_evt(evt[6]),
    .i_port1_overvolt_evt(evt[7]), .i_embedded_host_phy_down(phy_down),
    .o_irq_pin_out(pin_out), .o_irq_pin_oe(pin_oe));
  rie_host_model i_rie_host_model (.i_pin_out(pin_out), .i_pin_oe(pin_oe),
    .i_push_pull(pp), .i_active_low(pol), .o_pin_wire(),
    .o_irq_seen(irq_seen));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge clk);
    evt <= m;
    @(posedge clk);
    evt <= 8'h00;
  endtask
  // Hang guard; the plan needs only a few hundred cycles
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    finish_test();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'hB3, 8'h00);
    rd(8'hB4, 8'h00);
    wr(8'hB4, 8'hFF);
    rd(8'hB4, 8'hCF);
    wr(8'hB4, 8'h00);
    wr(8'hB3, 8'hA5);
    rd(8'hB3, 8'hA5);
    wr(8'h55, 8'h77);
    rd(8'h55, 8'h00);
    wr(8'hB3, 8'h00);
    foreach (ROWS[i]) begin
      wr(ROWS[i].ea, ROWS[i].ed);
      pulse(ROWS[i].evt);
      cyc(3);
      chk({7'h00, irq_seen}, 8'h01);
      rd(ROWS[i].sa, ROWS[i].sd);
      wr(ROWS[i].sa, ROWS[i].sd);
      cyc(3);
      chk({7'h00, irq_seen}, 8'h00);
      wr(ROWS[i].ea, 8'h00);
      pulse(ROWS[i].evt);
      cyc(3);
      chk({7'h00, irq_seen}, 8'h00);
      wr(ROWS[i].sa, 8'hFF);
    end
    // Attach must not count while the host phy is powered
    @(posedge clk);
    phy_down <= 1'b0;
    wr(8'hB4, 8'h04);
    pulse(8'h10);
    cyc(3);
    chk({7'h00, irq_seen}, 8'h00);
    wr(8'hB4, 8'h00);
    phy_down <= 1'b1;
    // Each pin direction: edge once, then level keeps re-setting
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      pins[k/2] <= ~k[0];
      cyc(6);
      wr(8'hA3, 8'hFF);
      wr(8'hB3, 8'h10 << k);
      @(posedge clk);
      pins[k/2] <= k[0];
      cyc(6);
      rd(8'hA3, 8'h10 << k);
      chk({7'h00, irq_seen}, 8'h01);
      wr(8'hA3, 8'h10 << k);
      cyc(4);
      rd(8'hA3, 8'h00);
      @(posedge clk);
      trig[k/2] <= 1'b1;
      cyc(6);
      wr(8'hA3, 8'hFF);
      rd(8'hA3, 8'h10 << k);
      @(posedge clk);
      trig[k/2] <= 1'b0;
      wr(8'hB3, 8'h00);
      wr(8'hA3, 8'hFF);
    end
    // Override level under every drive style and polarity
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      pp <= i[2];
      pol <= i[1];
      wr(8'hB2, {3'h0, i[2], i[1], 3'h0});
      wr(8'hB4, {1'b1, i[0], 6'h00});
      cyc(3);
      chk({7'h00, irq_seen}, {7'h00, i[0]});
      chk({7'h00, pin_oe}, {7'h00, i[2] | i[0]});
    end
    @(posedge clk);
    pp <= 1'b0;
    pol <= 1'b0;
    wr(8'hB2, 8'h00);
    wr(8'hB3, 8'h01);
    pulse(8'h02);
    wr(8'hB4, 8'h80);
    cyc(3);
    chk({7'h00, irq_seen}, 8'h00);
    wr(8'hB4, 8'h00);
    cyc(3);
    chk({7'h00, irq_seen}, 8'h01);
    // Reset in mid-run must clear the enables again
    wr(8'hB3, 8'hFF);
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(8'hB3, 8'h00);
    rd(8'hA3, 8'h00);
    finish_test();
  end
endmodule
